/* pkg/iox_pkg.sv */
// package for the indexed literal offset instruction executor
package iox_pkg;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned OFST_MAX = 95;
    localparam logic [7:0] OFST_LIMIT = 8'h5F;
    // opcode high bytes after masking the variable fields
    localparam logic [7:0] OP_ADD_MASK = 8'hFD;
    localparam logic [7:0] OP_ADD_VAL = 8'h24;
    localparam logic [7:0] OP_BIT_MASK = 8'hF1;
    localparam logic [7:0] OP_BIT_VAL = 8'h80;
    localparam logic [7:0] OP_FILL_VAL = 8'h68;
    localparam int unsigned DEST_POS = 1;
    localparam int unsigned BSEL_LSB = 1;
    localparam logic [7:0] FILL_BYTE = 8'hFF;
    // status flag positions
    localparam int unsigned FLG_C = 0;
    localparam int unsigned FLG_DIGIT = 1;
    localparam int unsigned FLG_Z = 2;
    localparam int unsigned FLG_OVER = 3;
    localparam int unsigned FLG_N = 4;
    localparam logic [4:0] FLAGS_RST = 5'h00;
    localparam logic [7:0] ACC_RST = 8'h00;

    typedef enum logic [1:0] {
        IOX_Q1_DECODE = 2'b00,
        IOX_Q2_READ = 2'b01,
        IOX_Q3_PROC = 2'b10,
        IOX_Q4_WRITE = 2'b11
    } iox_phase_e;

    typedef enum logic [1:0] {
        IOX_OP_NONE = 2'b00,
        IOX_OP_ADD = 2'b01,
        IOX_OP_BIT = 2'b10,
        IOX_OP_FILL = 2'b11
    } iox_op_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic we;
        logic re;
    } iox_mem_s;

    typedef struct packed {
        iox_op_e op;
        logic dest;
        logic [2:0] bsel;
        logic [7:0] ofst;
        logic ofst_ok;
    } iox_dec_s;
endpackage : iox_pkg

/* hdl/iox_decode.sv */
// combinational decoder for the three indexed instructions
module iox_decode
    import iox_pkg::*;
(
    input wire logic [15:0] instr,
    output iox_dec_s dec
);
    always_comb begin
        dec = '0;
        dec.ofst = instr[7:0];
        dec.ofst_ok = (instr[7:0] <= OFST_LIMIT);
        dec.dest = instr[8 + DEST_POS];
        dec.bsel = instr[8 + BSEL_LSB +: 3];
        if ((instr[15:8] & OP_ADD_MASK) == OP_ADD_VAL) begin // see RQ2
            dec.op = IOX_OP_ADD;
        end else if ((instr[15:8] & OP_BIT_MASK) == OP_BIT_VAL) begin // see RQ7
            dec.op = IOX_OP_BIT;
        end else if (instr[15:8] == OP_FILL_VAL) begin // see RQ8
            dec.op = IOX_OP_FILL;
        end else begin
            dec.op = IOX_OP_NONE;
        end
    end
endmodule : iox_decode

/* hdl/iox_exec.sv */
// four-phase executor for indexed add, bit set and fill instructions
// How it works
// RQ1: indexed add sums accumulator with byte at pointer plus offset 0..95
// RQ2: add recognised by high byte 0010 01d0, low byte is the offset
// RQ3: d=0 writes sum to accumulator, d=1 writes it back to memory
// RQ4: add updates negative, overflow, carry, digit carry and zero flags
// RQ5: each instruction is one word, one cycle of decode, read, process, write
// RQ6: bit set forces selected bit 0..7 of the addressed byte to one
// RQ7: bit set recognised by 1000 bbb0 plus offset; flags unchanged
// RQ8: fill encoded 0110 1000 plus offset writes FFh, flags unchanged
// RQ9: address is pointer plus zero-extended offset; pointer never modified
module iox_exec
    import iox_pkg::*;
#(
    parameter int unsigned AW = ADDR_W
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic instr_valid,
    input wire logic [15:0] instr,
    input wire logic [AW-1:0] indirect_pointer_two,
    input wire logic [DATA_W-1:0] mem_rdata,
    output logic [AW-1:0] mem_addr,
    output logic [DATA_W-1:0] mem_wdata,
    output logic mem_we,
    output logic mem_re,
    output logic [DATA_W-1:0] acc,
    output logic [4:0] status_flags,
    output logic busy,
    output logic done,
    output logic illegal
);
    typedef struct packed {
        iox_phase_e phase;
        iox_dec_s dec;
        logic [AW-1:0] addr;
        logic [DATA_W-1:0] operand;
        logic [DATA_W-1:0] result;
        logic [AW-1:0] mem_addr;
        logic [DATA_W-1:0] mem_wdata;
        logic mem_we;
        logic mem_re;
        logic [DATA_W-1:0] acc;
        logic [4:0] flags;
        logic busy;
        logic done;
        logic illegal;
    } iox_state_s;

    iox_state_s st_r;
    iox_state_s st_nxt;
    iox_dec_s dec_w;
    logic [DATA_W:0] sum_w;
    logic [4:0] half_w;
    logic [DATA_W-1:0] bit_w;

    iox_decode u_dec (
        .instr(instr),
        .dec(dec_w)
    );

    assign sum_w = {1'b0, st_r.acc} + {1'b0, st_r.operand}; // see RQ1
    assign half_w = {1'b0, st_r.acc[3:0]} + {1'b0, st_r.operand[3:0]};
    // one-hot mask of the selected bit; the a_bit_others assertion reuses it to check the untouched bits
    assign bit_w = DATA_W'(1) << st_r.dec.bsel; // see RQ6

    always_comb begin
        st_nxt = st_r;
        st_nxt.mem_we = 1'b0;
        st_nxt.mem_re = 1'b0;
        st_nxt.done = 1'b0;
        st_nxt.illegal = 1'b0;
        case (st_r.phase)
            IOX_Q1_DECODE: begin
                // unknown opcodes or offsets past 95 are flagged, not executed
                if (instr_valid) begin
                    if (dec_w.op != IOX_OP_NONE && dec_w.ofst_ok) begin
                        st_nxt.dec = dec_w;
                        // pointer is only read, never written
                        st_nxt.addr = indirect_pointer_two + AW'(dec_w.ofst); // see RQ9
                        st_nxt.phase = IOX_Q2_READ; // see RQ5
                        st_nxt.busy = 1'b1;
                        st_nxt.mem_addr = indirect_pointer_two + AW'(dec_w.ofst);
                        st_nxt.mem_re = (dec_w.op != IOX_OP_FILL);
                    end else begin
                        st_nxt.illegal = 1'b1;
                    end
                end
            end
            IOX_Q2_READ: begin
                // memory must answer within the cycle that mem_re stands
                st_nxt.operand = mem_rdata;
                st_nxt.phase = IOX_Q3_PROC;
            end
            IOX_Q3_PROC: begin
                case (st_r.dec.op)
                    IOX_OP_ADD: begin
                        st_nxt.result = sum_w[DATA_W-1:0];
                        st_nxt.flags[FLG_C] = sum_w[DATA_W]; // see RQ4
                        st_nxt.flags[FLG_DIGIT] = half_w[4];
                        st_nxt.flags[FLG_Z] = (sum_w[DATA_W-1:0] == 8'h00);
                        st_nxt.flags[FLG_N] = sum_w[DATA_W-1];
                        st_nxt.flags[FLG_OVER] = (st_r.acc[7] == st_r.operand[7]) && (sum_w[7] != st_r.acc[7]);
                    end
                    IOX_OP_BIT: st_nxt.result = st_r.operand | bit_w; // see RQ6
                    IOX_OP_FILL: st_nxt.result = FILL_BYTE; // see RQ8
                    default: st_nxt.result = st_r.operand;
                endcase
                st_nxt.phase = IOX_Q4_WRITE;
            end
            IOX_Q4_WRITE: begin
                if (st_r.dec.op == IOX_OP_ADD && !st_r.dec.dest) begin
                    st_nxt.acc = st_r.result; // see RQ3
                end else begin
                    st_nxt.mem_addr = st_r.addr;
                    st_nxt.mem_wdata = st_r.result;
                    st_nxt.mem_we = 1'b1; // see RQ3
                end
                st_nxt.phase = IOX_Q1_DECODE;
                st_nxt.busy = 1'b0;
                st_nxt.done = 1'b1;
            end
            default: st_nxt.phase = IOX_Q1_DECODE;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign mem_addr = st_r.mem_addr;
    assign mem_wdata = st_r.mem_wdata;
    assign mem_we = st_r.mem_we;
    assign mem_re = st_r.mem_re;
    assign acc = st_r.acc;
    assign status_flags = st_r.flags;
    assign busy = st_r.busy;
    assign done = st_r.done;
    assign illegal = st_r.illegal;

    a_done_spacing: assert property (@(posedge clk) disable iff (sys_rst) // see RQ5
        (st_r.phase == IOX_Q1_DECODE && st_nxt.phase == IOX_Q2_READ) |-> ##4 done)
        else $error("instruction did not finish in four phases");
    a_fill_value: assert property (@(posedge clk) disable iff (sys_rst) // see RQ8
        (done && st_r.dec.op == IOX_OP_FILL) |-> (mem_we && mem_wdata == 8'hFF))
        else $error("fill did not write all ones");
    a_flags_hold: assert property (@(posedge clk) disable iff (sys_rst) // see RQ7
        (st_r.busy && st_r.dec.op != IOX_OP_ADD) |=> $stable(status_flags))
        else $error("flags changed on non-add instruction");
    a_bit_set: assert property (@(posedge clk) disable iff (sys_rst) // see RQ6
        (done && st_r.dec.op == IOX_OP_BIT) |-> mem_wdata[st_r.dec.bsel])
        else $error("selected bit not set");
    a_addr_calc: assert property (@(posedge clk) disable iff (sys_rst) // see RQ9
        (mem_we) |-> (mem_addr == st_r.addr))
        else $error("write address mismatch");
    a_acc_dest: assert property (@(posedge clk) disable iff (sys_rst) // see RQ3
        (done && st_r.dec.op == IOX_OP_ADD) |-> (mem_we == st_r.dec.dest))
        else $error("add destination wrong");
    a_add_sum: assert property (@(posedge clk) disable iff (sys_rst) // see RQ1
        (st_r.phase == IOX_Q3_PROC && st_r.dec.op == IOX_OP_ADD) |=>
        (st_r.result == 8'($past(st_r.acc) + $past(st_r.operand))))
        else $error("sum wrong");
    a_zero_flag: assert property (@(posedge clk) disable iff (sys_rst) // see RQ4
        (st_r.phase == IOX_Q4_WRITE && st_r.dec.op == IOX_OP_ADD) |->
        (status_flags[FLG_Z] == (st_r.result == 8'h00)))
        else $error("zero flag wrong");
    a_decode_add: assert property (@(posedge clk) disable iff (sys_rst) // see RQ2
        (st_r.phase == IOX_Q1_DECODE && instr_valid && instr[15:10] == 6'h09 && !instr[8] &&
        instr[7:0] <= OFST_LIMIT) |=> (st_r.dec.op == IOX_OP_ADD))
        else $error("add not decoded");

    // operand, result and decode stay held until the next accept, so the checks below may read them late
    a_addr_sample: assert property (@(posedge clk) disable iff (sys_rst) // see RQ9
        $rose(busy) |->
        (st_r.addr == $past(indirect_pointer_two) + AW'($past(instr[7:0]))))
        else $error("effective address not pointer plus offset");
    a_read_strobe: assert property (@(posedge clk) disable iff (sys_rst) // see RQ5
        $rose(busy) |->
        (mem_re == (st_r.dec.op != IOX_OP_FILL)))
        else $error("read strobe wrong for instruction");
    a_busy_span: assert property (@(posedge clk) disable iff (sys_rst) // see RQ5
        $rose(busy) |->
        (busy [*3] ##1 !busy))
        else $error("busy did not span three cycles");
    a_illegal_pulse: assert property (@(posedge clk) disable iff (sys_rst) // see RQ2
        (st_r.phase == IOX_Q1_DECODE && instr_valid && dec_w.op == IOX_OP_NONE) |=>
        (illegal && !busy && !mem_re))
        else $error("unknown opcode not refused");
    a_offset_limit: assert property (@(posedge clk) disable iff (sys_rst) // see RQ1
        (st_r.phase == IOX_Q1_DECODE && instr_valid && instr[7:0] > OFST_LIMIT) |=>
        (illegal && !busy))
        else $error("offset past limit not refused");
    a_carry_flag: assert property (@(posedge clk) disable iff (sys_rst) // see RQ4
        (st_r.phase == IOX_Q4_WRITE && st_r.dec.op == IOX_OP_ADD) |->
        ({status_flags[FLG_C], st_r.result} == {1'b0, st_r.acc} + {1'b0, st_r.operand}))
        else $error("carry flag wrong");
    a_overflow_flag: assert property (@(posedge clk) disable iff (sys_rst) // see RQ4
        (st_r.phase == IOX_Q4_WRITE && st_r.dec.op == IOX_OP_ADD) |->
        (status_flags[FLG_OVER] == (st_r.acc[7] == st_r.operand[7] && st_r.result[7] != st_r.acc[7])))
        else $error("overflow flag wrong");
    a_digit_carry: assert property (@(posedge clk) disable iff (sys_rst) // see RQ4
        (st_r.phase == IOX_Q4_WRITE && st_r.dec.op == IOX_OP_ADD) |->
        (status_flags[FLG_DIGIT] == ({1'b0, st_r.acc[3:0]} + {1'b0, st_r.operand[3:0]} > 5'h0F)))
        else $error("digit carry flag wrong");
    a_neg_flag: assert property (@(posedge clk) disable iff (sys_rst) // see RQ4
        (st_r.phase == IOX_Q4_WRITE && st_r.dec.op == IOX_OP_ADD) |->
        (status_flags[FLG_N] == st_r.result[DATA_W-1]))
        else $error("negative flag wrong");
    a_bit_others: assert property (@(posedge clk) disable iff (sys_rst) // see RQ6
        (done && st_r.dec.op == IOX_OP_BIT) |->
        ((mem_wdata & ~bit_w) == (st_r.operand & ~bit_w)))
        else $error("bit set disturbed other bits");
    a_acc_kept: assert property (@(posedge clk) disable iff (sys_rst) // see RQ3
        (done && !(st_r.dec.op == IOX_OP_ADD && !st_r.dec.dest)) |->
        $stable(acc))
        else $error("accumulator changed without add to it");
    a_write_done: assert property (@(posedge clk) disable iff (sys_rst) // see RQ5
        mem_we |->
        done)
        else $error("memory written outside write phase");
endmodule : iox_exec

/* verif/tb.sv */
// self-checking bench for the indexed instruction executor
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import iox_pkg::*;
    logic clk = 1'b0, sys_rst = 1'b1, instr_valid = 1'b0, mem_we, mem_re, busy, done, illegal;
    logic [15:0] instr = 16'h0000;
    logic [11:0] ptr = 12'h000, mem_addr;
    logic [7:0] mem_rdata = 8'h00, mem_wdata, acc, ea = 8'h00;
    logic [4:0] status_flags, ef = 5'h00;
    logic [7:0] mem [0:4095];
    logic [7:0] em [0:4095];
    int fails = 0, compares = 0, seed = 76701, i;
    iox_exec dut (.clk(clk), .sys_rst(sys_rst), .instr_valid(instr_valid), .instr(instr),
        .indirect_pointer_two(ptr), .mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_we(mem_we), .mem_re(mem_re), .acc(acc), .status_flags(status_flags), .busy(busy),
        .done(done), .illegal(illegal));
    initial forever #2.5 clk = ~clk;
    // memory answers mid-cycle while the strobe stands; otherwise the data toggles
    always @(negedge clk) mem_rdata <= mem_re ? mem[mem_addr] : ~mem_rdata;
    always @(posedge clk) if (mem_we) mem[mem_addr] <= mem_wdata;
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task give_verdict;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict
    // called at a falling edge; returns at the falling edge of the done cycle, or of the illegal cycle for a refused instruction
    task run(input logic [15:0] ins, input logic [11:0] p);
        int n, s, a;
        logic [7:0] hi, opd, w;
        logic ad, bs, fl, wr;
        hi = ins[15:8];
        a = p + ins[7:0];
        ad = (hi & OP_ADD_MASK) == OP_ADD_VAL;
        bs = (hi & OP_BIT_MASK) == OP_BIT_VAL;
        fl = hi == OP_FILL_VAL;
        opd = em[a[11:0]];
        instr_valid = 1'b1;
        instr = ins;
        ptr = p;
        @(negedge clk);
        instr_valid = 1'b0;
        ptr = ~p; // pointer is only sampled at decode
        if (!(ad || bs || fl) || ins[7:0] > OFST_MAX) begin
            chk(16'(illegal), 16'h0001);
            chk(16'(mem_re), 16'h0000);
            return;
        end
        chk(16'(mem_re), 16'(!fl));
        chk(16'(busy), 16'h0001);
        chk(16'(mem_addr), 16'(a[11:0]));
        s = ea + opd;
        w = fl ? FILL_BYTE : bs ? opd | (8'h01 << ins[11:9]) : s[7:0];
        wr = !ad || ins[9];
        if (ad) ef = {w[7], ea[7] == opd[7] && w[7] != ea[7], w == 8'h00, (ea & 15) + (opd & 15) > 15, s > 255};
        if (ad && !ins[9]) ea = w;
        if (wr) em[a[11:0]] = w;
        n = 1;
        while (done !== 1'b1 && n < 8) begin
            @(negedge clk);
            n++;
        end
        chk(16'(n), 16'h0004);
        chk(16'(busy), 16'h0000);
        chk(16'(mem_we), 16'(wr));
        if (wr) chk(16'(mem_wdata), 16'(w));
        if (wr) chk(16'(mem_addr), 16'(a[11:0]));
        chk(16'(acc), 16'(ea));
        chk(16'(status_flags), 16'(ef));
    endtask : run
    initial begin
        #20000;
        fails++;
        give_verdict;
    end
    initial begin
        for (i = 0; i < 4096; i++) begin
            mem[i] = 8'($random(seed));
            em[i] = mem[i];
        end
        repeat (16) @(negedge clk);
        chk({acc, status_flags, busy, done, illegal}, 16'h0000);
        sys_rst = 1'b0;
        @(negedge clk);
        run(16'h242C, 12'hA00);
        run(16'h2600, 12'h123);
        run(16'h8E5F, 12'hA00);
        run(16'h685F, 12'hFA0);
        for (i = 0; i < 8; i++) run({4'h8, i[2:0], 1'b0, 8'h0A}, 12'h300);
        $display("test fixed cases done");
        run(16'h2460, 12'h100);
        run(16'hFF10, 12'h100);
        run(16'h6960, 12'h100);
        $display("test refusals done");
        for (i = 0; i < 40; i++) begin
            case ({$random(seed)} % 3)
                0: instr = {6'b001001, 1'($random(seed)), 1'b0, 8'h00};
                1: instr = {4'h8, 3'($random(seed)), 1'b0, 8'h00};
                default: instr = {OP_FILL_VAL, 8'h00};
            endcase
            run({instr[15:8], 8'({$random(seed)} % 96)}, 12'({$random(seed)} % 3900));
        end
        $display("test random mix done");
        give_verdict;
    end
endmodule : tb
